// file: logic/ccpt_top.sv
// Design decisions made here: the placing of the registers and the Wishbone register port.
`timescale 1ns/1ps
`include "ccpt_params.svh"

// Operation
// R01: 8-bit count and limit registers; interrupt when count matches limit.
// R02: prescale field bits 1-0 divides by 1, 4 or 16.
// R03: postscale field bits 6-3 divides match events by value plus one.
// R04: control bit 2 runs the timer; cleared it stops counting.
// R05: count write, control write and reset clear prescaler and postscaler.
// R06: control write keeps the count value; only scalers are cleared.
// R07: timer control bits 15-7 read as zero.
// R08: capture and compare use the full 16-bit capture timer.
// R09: PWM time base picks either period timer by a select register.
// R10: 10-bit duty: low two bits in control 5-4, upper eight in duty byte.
// R11: 10-bit time base is timer value plus two low prescaler bits.
// R12: mode 0000 disables the channel and resets its internal state.
// R13: capture on falling, rising, every 4th or 16th rising edge.
// R14: mode 1000 drives pin low, then high on match, sets flag.
// R15: mode 1001 drives pin high, then low on match, sets flag.
// R16: mode 0010 toggles the pin on each match and sets flag.
// R17: mode 1010 only sets the flag; pin stays with its port.
// R18: mode 1011 sets flag and resets capture timer; no conversion start.
// R19: mode 1100 is PWM; other unlisted codes are reserved.
// R20: software picks the mode before the pin takes its function.
// R21: channel control bits 15-6 read as zero.
// R22: software enables capture timer clock synchronisation for external clocks.
// R23: PWM goes active at period restart, inactive when time base reaches duty.
module ccpt_top
  import ccpt_pkg::*;
(
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // capture timer
  input wire logic [15:0] capture_timer_i,
  output logic capture_timer_reset_o,
  // alternate period timer
  input wire logic [7:0] alt_period_timer_count_i,
  input wire logic [1:0] alt_period_timer_low_i,
  input wire logic alt_period_match_i,
  // channel pin
  input wire logic channel_pin_i,
  output logic channel_pin_o,
  output logic channel_pin_oe_n_o,
  // event flags
  output logic channel_irq_flag_o,
  output logic period_timer_irq_o
);

  // merge bus byte lanes into a 16-bit register
  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] d,
                                          input logic [3:0] sel);
    logic [15:0] r;
    r = old;
    if (sel[0])
      r[7:0] = d[7:0];
    if (sel[1])
      r[15:8] = d[15:8];
    return r;
  endfunction

  function automatic ccpt_ch_state_t mode_state(input logic [3:0] mode);
    ccpt_ch_state_t s;
    case (mode)
      `CCPT_M_CAP_FALL, `CCPT_M_CAP_RISE, `CCPT_M_CAP_4, `CCPT_M_CAP_16: s = CH_CAP;
      `CCPT_M_TOGGLE, `CCPT_M_CMP_SET, `CCPT_M_CMP_CLR, `CCPT_M_CMP_SWI,
      `CCPT_M_CMP_SEV: s = CH_CMP;
      `CCPT_M_PWM: s = CH_PWM;
      default: s = CH_OFF;
    endcase
    return s;
  endfunction

  // bus and register state
  logic ack_reg, ack_next;
  logic [31:0] dat_reg, dat_next;
  logic [`CCPT_TC_W-1:0] tctrl_reg, tctrl_next;
  logic [7:0] limit_reg, limit_next;
  logic [`CCPT_CC_W-1:0] cctrl_reg, cctrl_next;
  logic [15:0] cval_reg, cval_next;
  logic tbsel_reg, tbsel_next;
  logic cflag_reg, cflag_next;
  logic tflag_reg, tflag_next;
  // channel state
  logic sync1_reg, sync2_reg, pin_prev_reg;
  logic sync1_next, sync2_next, pin_prev_next;
  logic [3:0] cap_cnt_reg, cap_cnt_next;
  logic pin_out_reg, pin_out_next;
  logic hit_prev_reg, hit_prev_next;
  logic [9:0] duty_lat_reg, duty_lat_next;
  logic sev_reg, sev_next;
  logic arm_reg, arm_next;

  logic req, wr;
  logic wr_tctrl, wr_tcount, wr_cctrl;
  logic [15:0] tctrl_m, cctrl_m, limit_m, tbsel_m, status_m;
  logic [7:0] tcount;
  logic [1:0] tlow;
  logic tmatch, tirq;
  logic [3:0] mode, new_mode;
  ccpt_ch_state_t chs;
  logic rise, fall, cap_evt, hit, cmp_evt;
  logic restart;
  logic [9:0] tbase, duty_now;

  ccpt_period_timer #(
    .WIDTH(8)
  ) i_ccpt_period_timer (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .on_i(tctrl_reg[`CCPT_TC_ON]), // see R04
    .prescale_sel_i(tctrl_reg[`CCPT_TC_PRE]),
    .postscale_sel_i(tctrl_reg[`CCPT_TC_POST]),
    .limit_i(limit_reg),
    .clear_scalers_i(wr_tctrl), // see R06
    .count_wr_i(wr_tcount),
    .count_wdata_i(wb_dat_i[7:0]),
    .count_o(tcount),
    .low_bits_o(tlow),
    .match_o(tmatch),
    .irq_o(tirq)
  );

  always_comb
  begin
    req = wb_cyc_i & wb_stb_i;
    wr = req & wb_we_i & ack_reg;
    wr_tctrl = wr && (wb_adr_i == `CCPT_ADR_TCTRL) && wb_sel_i[0];
    wr_tcount = wr && (wb_adr_i == `CCPT_ADR_TCOUNT) && wb_sel_i[0];
    wr_cctrl = wr && (wb_adr_i == `CCPT_ADR_CCTRL) && wb_sel_i[0];
    tctrl_m = merge16({9'h000, tctrl_reg}, wb_dat_i, wb_sel_i);
    cctrl_m = merge16({10'h000, cctrl_reg}, wb_dat_i, wb_sel_i);
    limit_m = merge16({8'h00, limit_reg}, wb_dat_i, wb_sel_i);
    tbsel_m = merge16({15'h0000, tbsel_reg}, wb_dat_i, wb_sel_i);
    status_m = merge16(`CCPT_RST16, wb_dat_i, wb_sel_i);
    mode = cctrl_reg[`CCPT_CC_MODE];
    chs = mode_state(mode);
    new_mode = cctrl_m[`CCPT_CC_MODE];

    // pin edges from the synchronised input
    rise = sync2_reg & ~pin_prev_reg;
    fall = ~sync2_reg & pin_prev_reg;
    // compare fires once as the capture timer reaches the value
    hit = (capture_timer_i == cval_reg); // see R08
    cmp_evt = (chs == CH_CMP) && hit && !hit_prev_reg;

    // pwm time base from the selected period timer
    if (tbsel_reg) // see R09
    begin
      tbase = {tcount, tlow}; // see R11
      restart = tmatch;
    end
    else
    begin
      tbase = {alt_period_timer_count_i, alt_period_timer_low_i};
      restart = alt_period_match_i;
    end
    duty_now = {cval_reg[7:0], cctrl_reg[`CCPT_CC_DUTY]}; // see R10

    cap_evt = 1'b0;
    cap_cnt_next = cap_cnt_reg;
    case (mode) // see R13
      `CCPT_M_CAP_FALL: cap_evt = fall;
      `CCPT_M_CAP_RISE: cap_evt = rise;
      `CCPT_M_CAP_4:
      begin
        cap_evt = rise && (cap_cnt_reg == `CCPT_CAP_MAX4);
        if (rise)
          cap_cnt_next = cap_evt ? 4'h0 : cap_cnt_reg + 4'h1;
      end
      `CCPT_M_CAP_16:
      begin
        cap_evt = rise && (cap_cnt_reg == `CCPT_CAP_MAX16);
        if (rise)
          cap_cnt_next = cap_evt ? 4'h0 : cap_cnt_reg + 4'h1;
      end
      default: cap_cnt_next = 4'h0;
    endcase

    // bus answer one cycle after the request
    ack_next = req & ~ack_reg;
    dat_next = dat_reg;
    if (req && !ack_reg)
    begin
      case (wb_adr_i)
        `CCPT_ADR_TCTRL: dat_next = {25'h0000000, tctrl_reg}; // see R07
        `CCPT_ADR_TCOUNT: dat_next = {24'h000000, tcount};
        `CCPT_ADR_TLIMIT: dat_next = {24'h000000, limit_reg};
        `CCPT_ADR_CCTRL: dat_next = {26'h0000000, cctrl_reg}; // see R21
        `CCPT_ADR_CVALUE: dat_next = {16'h0000, cval_reg};
        `CCPT_ADR_TBSEL: dat_next = {31'h00000000, tbsel_reg};
        `CCPT_ADR_STATUS: dat_next = {30'h00000000, tflag_reg, cflag_reg};
        default: dat_next = 32'h00000000;
      endcase
    end

    tctrl_next = tctrl_reg;
    limit_next = limit_reg;
    cctrl_next = cctrl_reg;
    cval_next = cval_reg;
    tbsel_next = tbsel_reg;
    if (wr)
    begin
      case (wb_adr_i)
        `CCPT_ADR_TCTRL: tctrl_next = tctrl_m[`CCPT_TC_W-1:0];
        `CCPT_ADR_TLIMIT: limit_next = limit_m[7:0];
        `CCPT_ADR_CCTRL: cctrl_next = cctrl_m[`CCPT_CC_W-1:0];
        `CCPT_ADR_CVALUE: cval_next = merge16(cval_reg, wb_dat_i, wb_sel_i);
        `CCPT_ADR_TBSEL: tbsel_next = tbsel_m[0];
        default: tbsel_next = tbsel_reg;
      endcase
    end
    // a capture outranks a software write in the same cycle
    if ((chs == CH_CAP) && cap_evt)
      cval_next = capture_timer_i;

    // sticky flags: hardware set wins over write-one-to-clear
    cflag_next = cflag_reg;
    tflag_next = tflag_reg;
    if (wr && (wb_adr_i == `CCPT_ADR_STATUS))
    begin
      cflag_next = cflag_reg & ~status_m[`CCPT_ST_CHAN];
      tflag_next = tflag_reg & ~status_m[`CCPT_ST_TIMER];
    end
    if (((chs == CH_CAP) && cap_evt) || cmp_evt) // see R14
      cflag_next = 1'b1;
    if (tirq) // see R01
      tflag_next = 1'b1;

    sync1_next = channel_pin_i;
    sync2_next = sync1_reg;
    pin_prev_next = sync2_reg;
    hit_prev_next = hit;
    pin_out_next = pin_out_reg;
    duty_lat_next = duty_lat_reg;
    sev_next = 1'b0;
    arm_next = 1'b0;
    case (mode)
      `CCPT_M_CMP_SET: if (cmp_evt) pin_out_next = 1'b1; // see R14
      `CCPT_M_CMP_CLR: if (cmp_evt) pin_out_next = 1'b0; // see R15
      `CCPT_M_TOGGLE: if (cmp_evt) pin_out_next = ~pin_out_reg; // see R16
      `CCPT_M_CMP_SEV: sev_next = cmp_evt; // see R18
      `CCPT_M_PWM:
      begin
        // rise one cycle after restart, matching the lag of the falling compare
        arm_next = restart;
        if (restart) // see R23
          duty_lat_next = duty_now;
        if (arm_reg)
          pin_out_next = (duty_lat_reg != 10'h000);
        else if (tbase >= duty_lat_reg)
          pin_out_next = 1'b0;
      end
      default: pin_out_next = pin_out_reg; // see R17
    endcase
    if (chs == CH_OFF) // see R12
    begin
      cap_cnt_next = 4'h0;
      pin_out_next = 1'b0;
      hit_prev_next = 1'b0;
      duty_lat_next = 10'h000;
      sev_next = 1'b0;
    end
    // a mode change sets up the pin level for the new function, also when leaving off
    if (wr_cctrl && (new_mode != mode))
    begin
      cap_cnt_next = 4'h0;
      hit_prev_next = 1'b1;
      duty_lat_next = 10'h000;
      pin_out_next = (new_mode == `CCPT_M_CMP_CLR); // see R15
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ack_reg <= 1'b0;
      dat_reg <= 32'h00000000;
      tctrl_reg <= `CCPT_TC_W'(`CCPT_RST16);
      limit_reg <= `CCPT_RST8;
      cctrl_reg <= `CCPT_CC_W'(`CCPT_RST16);
      cval_reg <= `CCPT_RST16;
      tbsel_reg <= 1'b0;
      cflag_reg <= 1'b0;
      tflag_reg <= 1'b0;
      sync1_reg <= 1'b0;
      sync2_reg <= 1'b0;
      pin_prev_reg <= 1'b0;
      cap_cnt_reg <= 4'h0;
      pin_out_reg <= 1'b0;
      hit_prev_reg <= 1'b0;
      duty_lat_reg <= 10'h000;
      sev_reg <= 1'b0;
      arm_reg <= 1'b0;
    end
    else
    begin
      ack_reg <= ack_next;
      dat_reg <= dat_next;
      tctrl_reg <= tctrl_next;
      limit_reg <= limit_next;
      cctrl_reg <= cctrl_next;
      cval_reg <= cval_next;
      tbsel_reg <= tbsel_next;
      cflag_reg <= cflag_next;
      tflag_reg <= tflag_next;
      sync1_reg <= sync1_next;
      sync2_reg <= sync2_next;
      pin_prev_reg <= pin_prev_next;
      cap_cnt_reg <= cap_cnt_next;
      pin_out_reg <= pin_out_next;
      hit_prev_reg <= hit_prev_next;
      duty_lat_reg <= duty_lat_next;
      sev_reg <= sev_next;
      arm_reg <= arm_next;
    end
  end

  always_comb
  begin
    wb_ack_o = ack_reg;
    wb_dat_o = dat_reg;
    capture_timer_reset_o = sev_reg; // see R18
    channel_pin_o = pin_out_reg;
    // pin driven in pin-owning compare modes and pwm only
    case (mode)
      `CCPT_M_CMP_SET, `CCPT_M_CMP_CLR, `CCPT_M_TOGGLE, `CCPT_M_PWM:
        channel_pin_oe_n_o = 1'b0;
      default: channel_pin_oe_n_o = 1'b1; // see R19
    endcase
    channel_irq_flag_o = cflag_reg;
    period_timer_irq_o = tflag_reg;
  end

endmodule

// file: logic/ccpt_params.svh
`ifndef CCPT_PARAMS_SVH
`define CCPT_PARAMS_SVH

// register byte addresses on the bus
`define CCPT_ADR_TCTRL 8'h00
`define CCPT_ADR_TCOUNT 8'h04
`define CCPT_ADR_TLIMIT 8'h08
`define CCPT_ADR_CCTRL 8'h0C
`define CCPT_ADR_CVALUE 8'h10
`define CCPT_ADR_TBSEL 8'h14
`define CCPT_ADR_STATUS 8'h18

// reset values
`define CCPT_RST16 16'h0000
`define CCPT_RST8 8'h00

// period timer control fields
`define CCPT_TC_PRE 1:0
`define CCPT_TC_ON 2
`define CCPT_TC_POST 6:3
`define CCPT_TC_W 7

// channel control fields
`define CCPT_CC_MODE 3:0
`define CCPT_CC_DUTY 5:4
`define CCPT_CC_W 6

// status bits
`define CCPT_ST_CHAN 0
`define CCPT_ST_TIMER 1

// prescale codes and terminal counts
`define CCPT_PRE_1 2'h0
`define CCPT_PRE_4 2'h1
`define CCPT_PRE_MAX1 4'h0
`define CCPT_PRE_MAX4 4'h3
`define CCPT_PRE_MAX16 4'hF

// channel mode codes
`define CCPT_M_OFF 4'h0
`define CCPT_M_TOGGLE 4'h2
`define CCPT_M_CAP_FALL 4'h4
`define CCPT_M_CAP_RISE 4'h5
`define CCPT_M_CAP_4 4'h6
`define CCPT_M_CAP_16 4'h7
`define CCPT_M_CMP_SET 4'h8
`define CCPT_M_CMP_CLR 4'h9
`define CCPT_M_CMP_SWI 4'hA
`define CCPT_M_CMP_SEV 4'hB
`define CCPT_M_PWM 4'hC

// capture edge prescaler terminal counts
`define CCPT_CAP_MAX4 4'h3
`define CCPT_CAP_MAX16 4'hF

`endif

// file: logic/ccpt_pkg.sv
package ccpt_pkg;

  typedef enum logic [3:0] {
    CH_OFF = 4'b0001,
    CH_CAP = 4'b0010,
    CH_CMP = 4'b0100,
    CH_PWM = 4'b1000
  } ccpt_ch_state_t;

endpackage

// file: logic/ccpt_period_timer.sv
`timescale 1ns/1ps
`include "ccpt_params.svh"

module ccpt_period_timer
  import ccpt_pkg::*;
#(
  parameter int WIDTH = 8
)
(
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // configuration
  input wire logic on_i,
  input wire logic [1:0] prescale_sel_i,
  input wire logic [3:0] postscale_sel_i,
  input wire logic [WIDTH-1:0] limit_i,
  // software access
  input wire logic clear_scalers_i,
  input wire logic count_wr_i,
  input wire logic [WIDTH-1:0] count_wdata_i,
  // results
  output logic [WIDTH-1:0] count_o,
  output logic [1:0] low_bits_o,
  output logic match_o,
  output logic irq_o
);

  logic [3:0] pre_cnt_reg, pre_cnt_next;
  logic [3:0] post_cnt_reg, post_cnt_next;
  logic [WIDTH-1:0] count_reg, count_next;
  logic [3:0] pre_max;
  logic tick;
  logic clear;

  always_comb
  begin
    case (prescale_sel_i) // see R02
      `CCPT_PRE_1: pre_max = `CCPT_PRE_MAX1;
      `CCPT_PRE_4: pre_max = `CCPT_PRE_MAX4;
      default: pre_max = `CCPT_PRE_MAX16;
    endcase
    clear = clear_scalers_i | count_wr_i; // see R05
    tick = on_i && (pre_cnt_reg == pre_max); // see R04
    match_o = tick && (count_reg == limit_i); // see R01
    irq_o = match_o && (post_cnt_reg == postscale_sel_i) && !clear; // see R03
    pre_cnt_next = pre_cnt_reg;
    post_cnt_next = post_cnt_reg;
    count_next = count_reg;
    if (clear)
    begin
      pre_cnt_next = 4'h0;
      post_cnt_next = 4'h0;
    end
    else if (on_i)
    begin
      pre_cnt_next = tick ? 4'h0 : pre_cnt_reg + 4'h1;
      if (match_o)
        post_cnt_next = irq_o ? 4'h0 : post_cnt_reg + 4'h1;
    end
    if (count_wr_i)
      count_next = count_wdata_i;
    else if (match_o)
      count_next = '0;
    else if (tick)
      count_next = count_reg + 1'b1;
    // low time-base bits follow the prescaler phase
    case (prescale_sel_i) // see R11
      `CCPT_PRE_1: low_bits_o = 2'h0;
      `CCPT_PRE_4: low_bits_o = pre_cnt_reg[1:0];
      default: low_bits_o = pre_cnt_reg[3:2];
    endcase
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      pre_cnt_reg <= 4'h0; // see R05
      post_cnt_reg <= 4'h0;
      count_reg <= '0;
    end
    else
    begin
      pre_cnt_reg <= pre_cnt_next;
      post_cnt_reg <= post_cnt_next;
      count_reg <= count_next;
    end
  end

  assign count_o = count_reg;

endmodule

// file: verification/ccpt_pin_model.sv
`timescale 1ns/1ps
module ccpt_pin_model (
  // pin parties
  input wire logic src_i,
  input wire logic drv_i,
  input wire logic oe_n_i,
  // resolved wire
  output logic pin_o
);
  // the channel owns the wire only in a mode that drives it
  assign pin_o = oe_n_i ? src_i : drv_i;
endmodule

// file: verification/ccpt_top_assertions.sv
`timescale 1ns/1ps
`include "ccpt_params.svh"
module ccpt_top_assertions (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  // capture timer
  input wire logic [15:0] capture_timer_i,
  input wire logic capture_timer_reset_o,
  // alternate period timer
  input wire logic [7:0] alt_period_timer_count_i,
  input wire logic [1:0] alt_period_timer_low_i,
  input wire logic alt_period_match_i,
  // pin and flags
  input wire logic channel_pin_i,
  input wire logic channel_pin_o,
  input wire logic channel_pin_oe_n_o,
  input wire logic channel_irq_flag_o,
  input wire logic period_timer_irq_o
);
  logic [3:0] mode_reg, mode_next;
  logic [15:0] val_reg, val_next;
  logic wr_hit, rd_req;
  assign wr_hit = wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o;
  assign rd_req = wb_cyc_i && wb_stb_i && !wb_we_i && !wb_ack_o;
  // shadow of mode and compare value, updated where the write lands
  always_comb
  begin
    mode_next = mode_reg;
    val_next = val_reg;
    if (wr_hit && wb_adr_i == `CCPT_ADR_CCTRL)
      mode_next = wb_dat_i[3:0];
    if (wr_hit && wb_adr_i == `CCPT_ADR_CVALUE)
      val_next = wb_dat_i[15:0];
  end
  always_ff @(posedge clk_i)
  begin
    mode_reg <= rst_i ? 4'h0 : mode_next;
    val_reg <= rst_i ? 16'h0000 : val_next;
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // a match seen with mode and value settled
  sequence s_hit(logic [3:0] m);
    mode_reg == m && $stable(mode_reg) && $stable(val_reg) && capture_timer_i == val_reg;
  endsequence
  chk_tctrl_upper_zero: assert property (
    rd_req && wb_adr_i == `CCPT_ADR_TCTRL |=> wb_ack_o && wb_dat_o[31:7] == 25'h0000000)
    else $error("timer control upper bits not zero");
  chk_cctrl_upper_zero: assert property (
    rd_req && wb_adr_i == `CCPT_ADR_CCTRL |=> wb_ack_o && wb_dat_o[31:6] == 26'h0000000)
    else $error("channel control upper bits not zero");
  chk_pin_drive_mode: assert property (
    channel_pin_oe_n_o == !(mode_reg inside {4'h2, 4'h8, 4'h9, 4'hC}))
    else $error("pin drive enable wrong for mode");
  chk_match_sets_pin: assert property (
    s_hit(4'h8) |=> channel_pin_o && channel_irq_flag_o)
    else $error("set on match failed");
  chk_match_clears_pin: assert property (
    s_hit(4'h9) |=> !channel_pin_o && channel_irq_flag_o)
    else $error("clear on match failed");
  chk_match_toggles_pin: assert property (
    s_hit(4'h2) |=> channel_pin_o != $past(channel_pin_o) && channel_irq_flag_o)
    else $error("toggle on match failed");
  chk_match_flag_only: assert property (
    s_hit(4'hA) |=> channel_irq_flag_o && channel_pin_oe_n_o)
    else $error("flag only match failed");
  chk_event_follows: assert property (
    s_hit(4'hB) |-> ##[1:2] capture_timer_reset_o)
    else $error("special event missing");
  chk_event_source: assert property (
    capture_timer_reset_o |-> mode_reg == 4'hB ##1 !capture_timer_reset_o)
    else $error("special event outside its mode");
endmodule
bind ccpt_top ccpt_top_assertions i_ccpt_top_assertions (.clk_i, .rst_i, .wb_cyc_i,
  .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o,
  .capture_timer_i, .capture_timer_reset_o, .alt_period_timer_count_i,
  .alt_period_timer_low_i, .alt_period_match_i, .channel_pin_i, .channel_pin_o,
  .channel_pin_oe_n_o, .channel_irq_flag_o, .period_timer_irq_o);

// file: verification/ccpt_top_tb.sv
`timescale 1ns/1ps
`include "ccpt_params.svh"
module ccpt_top_tb;
  localparam logic [7:0] TC = `CCPT_ADR_TCTRL;
  localparam logic [7:0] CC = `CCPT_ADR_CCTRL;
  localparam logic [7:0] ST = `CCPT_ADR_STATUS;
  localparam logic [7:0] CV = `CCPT_ADR_CVALUE;
  localparam logic [1:0] PRE [5] = '{2'h0, 2'h1, 2'h2, 2'h3, 2'h0};
  localparam logic [3:0] POST [5] = '{4'h0, 4'h0, 4'h1, 4'h0, 4'hF};
  localparam int PER [5] = '{10, 40, 320, 160, 160};
  localparam logic [3:0] CM [5] = '{4'h8, 4'h9, 4'h2, 4'hA, 4'hB};
  localparam logic [31:0] C0 [3] = '{32'h0, 32'h1, 32'h0};
  localparam logic [31:0] C1 [3] = '{32'h1, 32'h0, 32'h1};
  localparam int NP [4] = '{1, 1, 5, 17};
  localparam int KK [4] = '{1, 1, 4, 16};
  localparam logic [7:0] DH [4] = '{8'h04, 8'h02, 8'h00, 8'hFF};
  localparam logic [1:0] DL [4] = '{2'h0, 2'h2, 2'h0, 2'h0};
  localparam int PW [4] = '{40, 30, 0, 100};
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc = 1'b0, stb = 1'b0, we = 1'b0, src = 1'b0, ct_clr = 1'b0, irq_d = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [31:0] wdat = 32'h0, rdat, dat_o;
  logic [15:0] ct = 16'h0000;
  logic [15:0] v;
  logic [7:0] alt_cnt = 8'h00;
  logic ack, sev, pin_o, oe_n, irq_c, irq_t, wire_pin;
  int n_mismatch = 0, samples_checked = 0, cycles = 0, n_rise = 0, per = 0, t_rise = 0;
  int hi_cnt = 0, sev_n = 0, k, h, s0;
  initial forever #5 clk_i = ~clk_i;
  ccpt_top i_ccpt_top (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(dat_o),
    .wb_ack_o(ack), .capture_timer_i(ct), .capture_timer_reset_o(sev),
    .alt_period_timer_count_i(alt_cnt), .alt_period_timer_low_i(2'h0),
    .alt_period_match_i(alt_cnt == 8'h04), .channel_pin_i(wire_pin), .channel_pin_o(pin_o),
    .channel_pin_oe_n_o(oe_n), .channel_irq_flag_o(irq_c), .period_timer_irq_o(irq_t));
  ccpt_pin_model i_ccpt_pin_model (.src_i(src), .drv_i(pin_o), .oe_n_i(oe_n),
    .pin_o(wire_pin));
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // one classic cycle, held until ack is sampled high
  task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    do @(posedge clk_i); while (ack !== 1'b1);
    rdat = dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    acc(1'b0, a, 32'h0);
    chk(rdat, exp);
  endtask
  // free running capture timer, period and pulse monitors, hang guard
  always @(posedge clk_i)
  begin
    cycles <= cycles + 1;
    // capture timer runs on the device clock, so it needs no synchroniser
    ct <= (ct_clr || sev === 1'b1) ? 16'h0000 : ct + 16'h0001;
    // alternate period timer: count 0 to 4, match at 4
    alt_cnt <= (alt_cnt == 8'h04) ? 8'h00 : alt_cnt + 8'h01;
    irq_d <= irq_t;
    if (pin_o === 1'b1)
      hi_cnt <= hi_cnt + 1;
    if (sev === 1'b1)
      sev_n <= sev_n + 1;
    if (irq_t === 1'b1 && irq_d !== 1'b1)
    begin
      per <= cycles - t_rise;
      t_rise <= cycles;
      n_rise <= n_rise + 1;
    end
    if (cycles > 20000)
    begin
      n_mismatch++;
      wrap_up();
    end
  end
  initial
  begin
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    rd_chk(TC, 32'h0);
    rd_chk(CC, 32'h0);
    rd_chk(8'h1C, 32'h0);
    acc(1'b1, TC, 32'h0000FFFF);
    rd_chk(TC, 32'h0000007F);
    acc(1'b1, CC, 32'h0000FFFF);
    rd_chk(CC, 32'h0000003F);
    chk(32'(oe_n), 32'h1);
    acc(1'b1, CC, 32'h0);
    acc(1'b1, TC, 32'h0);
    acc(1'b1, `CCPT_ADR_TCOUNT, 32'h5);
    acc(1'b1, TC, 32'h78);
    repeat (20) @(posedge clk_i);
    rd_chk(`CCPT_ADR_TCOUNT, 32'h5);
    $display("test registers done");
    acc(1'b1, `CCPT_ADR_TLIMIT, 32'h9);
    for (int i = 0; i < 5; i++)
    begin
      acc(1'b1, TC, {25'h0, POST[i], 1'b1, PRE[i]});
      for (int j = 0; j < 3; j++)
      begin
        acc(1'b1, ST, 32'h2);
        k = n_rise;
        wait (n_rise != k);
      end
      chk(per, PER[i]);
    end
    acc(1'b1, TC, 32'h0);
    $display("test period timer done");
    for (int i = 0; i < 5; i++)
    begin
      @(posedge clk_i) ct_clr <= 1'b1;
      @(posedge clk_i) ct_clr <= 1'b0;
      acc(1'b1, CC, 32'h0);
      acc(1'b1, CV, 32'h40);
      acc(1'b1, CC, {28'h0, CM[i]});
      acc(1'b1, ST, 32'h3);
      s0 = sev_n;
      if (i < 3)
        chk(32'(pin_o), C0[i]);
      // the special event restarts the capture timer before it gets that far
      wait (ct == 16'h0048 || sev_n != s0);
      @(posedge clk_i);
      chk(32'(irq_c), 32'h1);
      if (i < 3)
        chk(32'(pin_o), C1[i]);
      if (i == 3)
        chk(32'(oe_n), 32'h1);
      if (i == 4)
        chk(sev_n - s0, 32'h1);
    end
    $display("test compare done");
    for (int i = 0; i < 4; i++)
    begin
      acc(1'b1, CC, 32'h0);
      acc(1'b1, CC, 32'h4 + i);
      acc(1'b1, ST, 32'h3);
      for (int j = 1; j <= NP[i]; j++)
      begin
        @(posedge clk_i) src <= 1'b1;
        if (i > 0 && j == KK[i])
          v = ct + 16'h0003;
        repeat (4) @(posedge clk_i);
        src <= 1'b0;
        if (i == 0)
          v = ct + 16'h0003;
        repeat (4) @(posedge clk_i);
      end
      rd_chk(CV, {16'h0, v});
      rd_chk(ST, 32'h1);
    end
    $display("test capture done");
    acc(1'b1, `CCPT_ADR_TBSEL, 32'h1);
    acc(1'b1, TC, 32'h4);
    for (int i = 0; i < 4; i++)
    begin
      acc(1'b1, CV, {24'h0, DH[i]});
      acc(1'b1, CC, {26'h0, DL[i], 4'hC});
      repeat (30) @(posedge clk_i);
      h = hi_cnt;
      repeat (100) @(posedge clk_i);
      chk(hi_cnt - h, PW[i]);
    end
    // alternate timer as time base, duty 8 quarter steps of a 5-tick period
    acc(1'b1, `CCPT_ADR_TBSEL, 32'h0);
    acc(1'b1, CV, 32'h2);
    repeat (30) @(posedge clk_i);
    h = hi_cnt;
    repeat (100) @(posedge clk_i);
    chk(hi_cnt - h, 32'h28);
    $display("test pwm done");
    wrap_up();
  end
endmodule
